/* File: logic/psq_pkg.sv */
// Purpose: Constants and types for the program sequencer block.
// Assumes: 10 MHz mclk, AXI4-Lite register access, 32-bit data.
// Notes: Instruction encoding and register map are local to this block.

package psq_pkg;

    // ----------------------------------------------------------------
    // Sizes and vectors
    // ----------------------------------------------------------------
    localparam int PSQ_PC_W = 11;
    localparam int PSQ_WORD_W = 14;
    localparam int PSQ_STACK_DEPTH = 4;
    localparam int PSQ_RAM_WORDS = 32;
    localparam logic [10:0] PSQ_RESET_VECTOR = 11'h000;
    localparam logic [10:0] PSQ_INT_VECTOR = 11'h004;
    localparam logic [13:0] PSQ_NOP_WORD = 14'h0000;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_PC_LOW = 8'h00;
    localparam logic [7:0] OFF_TABLE_PTR = 8'h04;
    localparam logic [7:0] OFF_TABLE_HIGH = 8'h08;
    localparam logic [7:0] OFF_CONTROL = 8'h0C;
    localparam logic [7:0] OFF_STATE = 8'h10;
    localparam logic [7:0] OFF_PM_ADDR = 8'h14;
    localparam logic [7:0] OFF_PM_DATA = 8'h18;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_INT_EN_BIT = 1;
    localparam int ST_FLAGS_LSB = 0;
    localparam int ST_LEVEL_LSB = 4;
    localparam int ST_PEND_BIT = 7;
    localparam int ST_ACC_LSB = 8;
    localparam int ST_PC_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Status flag bits and data memory map
    // ----------------------------------------------------------------
    localparam int FL_C = 0;
    localparam int FL_AC = 1;
    localparam int FL_Z = 2;
    localparam int FL_OV = 3;
    localparam logic [4:0] MA_PC_LOW = 5'h00;
    localparam logic [4:0] MA_TABLE_PTR = 5'h01;
    localparam logic [4:0] MA_TABLE_HIGH = 5'h02;
    localparam logic [4:0] MA_STATUS = 5'h03;
    localparam logic [3:0] DAA_LIMIT = 4'h9;

    // ----------------------------------------------------------------
    // Instruction classes [13:11] and ALU operations [10:6]
    // ----------------------------------------------------------------
    localparam logic [2:0] CL_ALU = 3'h0;
    localparam logic [2:0] CL_JUMP = 3'h1;
    localparam logic [2:0] CL_CALL = 3'h2;
    localparam logic [2:0] CL_LOAD_ACC = 3'h3;
    localparam logic [4:0] OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03, OP_SBC = 5'h04;
    localparam logic [4:0] OP_DAA = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07, OP_XOR = 5'h08;
    localparam logic [4:0] OP_CPL = 5'h09, OP_RR = 5'h0A, OP_RRC = 5'h0B, OP_RL = 5'h0C;
    localparam logic [4:0] OP_RLC = 5'h0D, OP_INC = 5'h0E, OP_DEC = 5'h0F, OP_MOV = 5'h10;
    localparam logic [4:0] OP_SZ = 5'h11, OP_SNZ = 5'h12, OP_SIZ = 5'h13, OP_SDZ = 5'h14;
    localparam logic [4:0] OP_RET = 5'h15, OP_RETURN_FROM_INTERRUPT = 5'h16, OP_TABLE_READ_CURRENT_PAGE = 5'h17;
    localparam logic [4:0] OP_TABLE_READ_CURRENT_PAGE_LAST = 5'h18;

    typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} psq_phase_type;

endpackage

/* File: logic/psq_sequencer.sv */
// Purpose: Program sequencer with return stack, ALU and table reads.
// Assumes: AXI4-Lite master keeps one write and one read in flight.
// Notes: Program memory is loaded through the address/data register pair.
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module psq_sequencer import psq_pkg::*; #(
    parameter int PC_W = PSQ_PC_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt logic
    input wire logic irq_req,
    output logic irq_ack
);

    if (PC_W < 9 || PC_W > 11) begin : g_pc_w_check
        $error("PC_W must lie between 9 and 11");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [PSQ_WORD_W-1:0] pm [0:(2**PC_W)-1];
    logic [7:0] ram [0:PSQ_RAM_WORDS-1];
    logic [PC_W-1:0] stk [0:PSQ_STACK_DEPTH-1];
    logic [PC_W-1:0] pc, target, pm_addr, tab_addr;
    logic [PSQ_WORD_W-1:0] fetch_word, ir, tab_word;
    logic ir_valid;
    psq_phase_type phase;
    logic [7:0] acc, table_ptr, table_high, pcl_val, m, res, add_b;
    logic [3:0] flags, nf;
    logic [1:0] sp;
    logic [2:0] level;
    logic run, int_en, pcl_req, irq_s1, irq_s2, irq_s3, irq_pend;
    logic [7:0] aw_addr;
    logic [31:0] w_data, rd_mux;
    logic [3:0] w_strb;
    logic wr_fire, rd_hit, wr_hit, exec, add_ci, sub_op;
    logic [8:0] sum9, daa_lo, daa9;
    logic [4:0] half5;
    logic wr_acc, wr_mem, skip, branch, push, pop, tab, tab_last;
    logic pcl_w, int_take, pcl_bus, discard;
    wire [2:0] cls = ir[13:11];
    wire [4:0] op = ir[10:6];
    wire to_mem = ir[5];
    wire [4:0] maddr = ir[4:0];
    wire [PC_W-1:0] pc_back = pc - PC_W'(1);

    // ----------------------------------------------------------------
    // Phase sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_T1;
        end else if (run) begin
            unique case (phase)
                PH_T1: phase <= PH_T2;
                PH_T2: phase <= PH_T3;
                PH_T3: phase <= PH_T4;
                PH_T4: phase <= PH_T1;
            endcase
        end
    end

    assign exec = run && (phase == PH_T4);

    // ----------------------------------------------------------------
    // Operand fetch and ALU
    // ----------------------------------------------------------------
    always_comb begin
        unique case (maddr)
            MA_PC_LOW: m = pc[7:0];
            MA_TABLE_PTR: m = table_ptr;
            MA_TABLE_HIGH: m = table_high;
            MA_STATUS: m = {4'h0, flags};
            default: m = ram[maddr];
        endcase
    end

    always_comb begin
        if (tab_last) begin
            tab_addr = {{(PC_W-8){1'b1}}, table_ptr};
        end else begin
            tab_addr = {pc[PC_W-1:8], table_ptr};
        end
        tab_word = pm[tab_addr];
    end

    always_comb begin
        sub_op = (op == OP_SUB) || (op == OP_SBC);
        add_b = sub_op ? ~m : m;
        add_ci = ((op == OP_ADC) || (op == OP_SBC)) ? flags[FL_C] : sub_op;
        sum9 = {1'b0, acc} + {1'b0, add_b} + {8'h00, add_ci};
        half5 = {1'b0, acc[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};
        daa_lo = ((acc[3:0] > DAA_LIMIT) || flags[FL_AC]) ? {1'b0, acc} + 9'h006 : {1'b0, acc};
        daa9 = (daa_lo[8] || (daa_lo[7:4] > DAA_LIMIT) || flags[FL_C]) ? daa_lo + 9'h060
                                                                       : daa_lo;
        res = 8'h00;
        nf = flags;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        skip = 1'b0;
        branch = 1'b0;
        target = pc;
        push = 1'b0;
        pop = 1'b0;
        tab = 1'b0;
        tab_last = 1'b0;
        if (ir_valid) begin
            case (cls)
                CL_JUMP: begin
                    branch = 1'b1;
                    target = ir[PC_W-1:0];
                end
                CL_CALL: begin
                    branch = 1'b1;
                    push = 1'b1;
                    target = ir[PC_W-1:0];
                end
                CL_LOAD_ACC: begin
                    res = ir[7:0];
                    wr_acc = 1'b1;
                end
                CL_ALU: begin
                    wr_mem = to_mem;
                    wr_acc = !to_mem;
                    case (op)
                        OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
                            res = sum9[7:0];
                            nf[FL_C] = sum9[8];
                            nf[FL_AC] = half5[4];
                            nf[FL_OV] = (acc[7] == add_b[7]) && (sum9[7] != acc[7]);
                        end
                        OP_DAA: begin
                            res = daa9[7:0];
                            nf[FL_C] = flags[FL_C] || daa9[8] || daa_lo[8] || (daa9 != daa_lo);
                        end
                        OP_AND: res = acc & m;
                        OP_OR: res = acc | m;
                        OP_XOR: res = acc ^ m;
                        OP_CPL: res = ~m;
                        OP_RR: res = {m[0], m[7:1]};
                        OP_RRC: begin
                            res = {flags[FL_C], m[7:1]};
                            nf[FL_C] = m[0];
                        end
                        OP_RL: res = {m[6:0], m[7]};
                        OP_RLC: begin
                            res = {m[6:0], flags[FL_C]};
                            nf[FL_C] = m[7];
                        end
                        OP_INC, OP_SIZ: res = m + 8'h01;
                        OP_DEC, OP_SDZ: res = m - 8'h01;
                        OP_MOV: res = to_mem ? acc : m;
                        OP_SZ, OP_SNZ: begin
                            wr_mem = 1'b0;
                            wr_acc = 1'b0;
                        end
                        OP_RET, OP_RETURN_FROM_INTERRUPT: begin
                            wr_mem = 1'b0;
                            wr_acc = 1'b0;
                            pop = 1'b1;
                            branch = 1'b1;
                            target = stk[sp - 2'h1];
                        end
                        OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_CURRENT_PAGE_LAST: begin
                            tab = 1'b1;
                            tab_last = (op == OP_TABLE_READ_CURRENT_PAGE_LAST);
                            res = tab_word[7:0];
                            wr_mem = 1'b1;
                            wr_acc = 1'b0;
                        end
                        default: begin
                            wr_mem = 1'b0;
                            wr_acc = 1'b0;
                        end
                    endcase
                    if (op inside {OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC,
                                   OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA}) begin
                        nf[FL_Z] = (res == 8'h00);
                    end
                    // Skips test the operand or the stepped value
                    if (op == OP_SZ) skip = (m == 8'h00);
                    if (op == OP_SNZ) skip = (m != 8'h00);
                    if (op == OP_SIZ || op == OP_SDZ) skip = (res == 8'h00);
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control transfer priority
    // ----------------------------------------------------------------
    assign pcl_w = wr_mem && (maddr == MA_PC_LOW);
    assign int_take = irq_pend && int_en && (level < 3'(PSQ_STACK_DEPTH))
                      && !branch && !pcl_w && !tab && !skip;
    // Bus jumps wait for a quiet boundary, never preempting a branch
    assign pcl_bus = pcl_req && !(branch || pcl_w || tab || skip || int_take);
    assign discard = branch || pcl_w || tab || skip || int_take || pcl_bus;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc <= PC_W'(PSQ_RESET_VECTOR);
        end else if (run && phase == PH_T1) begin
            pc <= pc + PC_W'(1);
        end else if (exec) begin
            if (branch) begin
                pc <= target;
            end else if (pcl_w) begin
                pc <= {pc[PC_W-1:8], res};
            end else if (tab) begin
                pc <= pc_back;
            end else if (int_take) begin
                pc <= PC_W'(PSQ_INT_VECTOR);
            end else if (pcl_bus) begin
                pc <= {pc[PC_W-1:8], pcl_val};
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_word <= PSQ_NOP_WORD;
            ir <= PSQ_NOP_WORD;
            ir_valid <= 1'b0;
        end else if (run && phase == PH_T1) begin
            fetch_word <= pm[pc];
        end else if (exec) begin
            ir <= discard ? PSQ_NOP_WORD : fetch_word;
            ir_valid <= !discard;
        end
    end

    // ----------------------------------------------------------------
    // Return stack (circular, so overflow drops the oldest entry)
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sp <= 2'h0;
            level <= 3'h0;
        end else if (exec && (push || int_take)) begin
            sp <= sp + 2'h1;
            if (level != 3'(PSQ_STACK_DEPTH)) level <= level + 3'h1;
        end else if (exec && pop) begin
            sp <= sp - 2'h1;
            if (level != 3'h0) level <= level - 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (exec && (push || int_take)) stk[sp] <= pc_back;
    end

    // ----------------------------------------------------------------
    // Datapath registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= 8'h00;
        end else if (exec && wr_acc) begin
            acc <= res;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= 4'h0;
        end else if (exec && wr_mem && maddr == MA_STATUS) begin
            flags <= res[3:0];
        end else if (exec) begin
            flags <= nf;
        end
    end

    always_ff @(posedge mclk) begin
        if (exec && wr_mem && maddr > MA_STATUS) ram[maddr] <= res;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            table_high <= 8'h00;
        end else if (exec && tab) begin
            table_high <= {2'h0, tab_word[13:8]};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            table_ptr <= 8'h00;
        end else if (wr_hit && aw_addr == OFF_TABLE_PTR && w_strb[0]) begin
            table_ptr <= w_data[7:0];
        end else if (exec && wr_mem && maddr == MA_TABLE_PTR) begin
            table_ptr <= res;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request capture
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_s1 <= 1'b0;
            irq_s2 <= 1'b0;
            irq_s3 <= 1'b0;
            irq_pend <= 1'b0;
            irq_ack <= 1'b0;
        end else begin
            irq_s1 <= irq_req;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
            // New request wins over the acknowledge clear
            irq_pend <= (irq_pend && !(exec && int_take)) || (irq_s2 && !irq_s3);
            irq_ack <= exec && int_take;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_hit = wr_fire && (aw_addr == OFF_PC_LOW || aw_addr == OFF_TABLE_PTR ||
                                aw_addr == OFF_CONTROL || aw_addr == OFF_PM_ADDR ||
                                aw_addr == OFF_PM_DATA);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_hit || aw_addr == OFF_TABLE_HIGH ||
                                aw_addr == OFF_STATE) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Control, bus jump request and program memory port
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run <= 1'b0;
            int_en <= 1'b0;
            pcl_req <= 1'b0;
            pcl_val <= 8'h00;
            pm_addr <= '0;
        end else begin
            if (wr_hit && aw_addr == OFF_CONTROL && w_strb[0]) begin
                run <= w_data[CTRL_RUN_BIT];
                int_en <= w_data[CTRL_INT_EN_BIT];
            end
            // Set wins over the clear on apply
            if (wr_hit && aw_addr == OFF_PC_LOW && w_strb[0]) begin
                pcl_req <= 1'b1;
                pcl_val <= w_data[7:0];
            end else if (exec && pcl_bus) begin
                pcl_req <= 1'b0;
            end
            if (wr_hit && aw_addr == OFF_PM_ADDR && (&w_strb[1:0])) begin
                pm_addr <= w_data[PC_W-1:0];
            end else if (wr_hit && aw_addr == OFF_PM_DATA && (&w_strb[1:0])) begin
                pm_addr <= pm_addr + PC_W'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (wr_hit && aw_addr == OFF_PM_DATA && (&w_strb[1:0])) begin
            pm[pm_addr] <= w_data[PSQ_WORD_W-1:0];
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case ({s_axi_araddr[7:2], 2'h0})
            OFF_PC_LOW: rd_mux[7:0] = pc[7:0];
            OFF_TABLE_PTR: rd_mux[7:0] = table_ptr;
            OFF_TABLE_HIGH: rd_mux[7:0] = table_high;
            OFF_CONTROL: begin
                rd_mux[CTRL_RUN_BIT] = run;
                rd_mux[CTRL_INT_EN_BIT] = int_en;
            end
            OFF_STATE: begin
                rd_mux[ST_FLAGS_LSB +: 4] = flags;
                rd_mux[ST_LEVEL_LSB +: 3] = level;
                rd_mux[ST_PEND_BIT] = irq_pend;
                rd_mux[ST_ACC_LSB +: 8] = acc;
                rd_mux[ST_PC_LSB +: PC_W] = pc;
            end
            OFF_PM_ADDR: rd_mux[PC_W-1:0] = pm_addr;
            OFF_PM_DATA: rd_mux[PSQ_WORD_W-1:0] = pm[pm_addr];
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // psq_sequencer

`default_nettype wire

/* File: verification/psq_seq_asserts.sv */
// Purpose: Bus and interrupt timing checks
// Assumes: One mclk domain
// Notes: Sees top-level ports only
`timescale 1ns/1ps
`default_nettype none
module psq_seq_asserts (
    // Watched ports
    input wire logic mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic s_axi_rready, irq_ack,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read answer stuck");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_pcl_byte: assert property (s_rd_taken ##0 s_axi_araddr == 8'h00 |=> s_axi_rdata[31:8] == 24'h0)
        else $error("pc low wider than a byte");
    a_ack_spacing: assert property (irq_ack |=> !irq_ack [*3])
        else $error("ack inside one instruction cycle");
endmodule // psq_seq_asserts
bind psq_sequencer psq_seq_asserts i_psq_seq_asserts (.*);
`default_nettype wire

/* File: verification/psq_irq_source.sv */
// Purpose: Interrupt request source facing the sequencer
// Assumes: Level request
// Notes: Request held until acknowledged, like a peripheral flag
`timescale 1ns/1ps
`default_nettype none
module psq_irq_source (
    // Clock, reset, control
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic fire,
    // Interrupt pair
    input wire logic irq_ack,
    output logic irq_req,
    output logic [3:0] acks
);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req <= 1'b0;
            acks <= 4'h0;
        end else begin
            acks <= acks + {3'h0, irq_ack};
            irq_req <= fire | (irq_req & ~irq_ack);
        end
    end
endmodule // psq_irq_source
`default_nettype wire

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the sequencer
// Assumes: Program loaded over the register bus before run
// Notes: Short program keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module testbench import psq_pkg::*;;
    logic mclk = 1'b0;
    logic rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic irq_req, irq_ack, fire;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, acks;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    // Call at 3 runs 7..11: move, add, skip over a load, return to the loop at 4
    logic [13:0] prog [12] = '{14'h1806, 14'h0421, 14'h0624, 14'h1007, 14'h0000, 14'h0804,
                               14'h0000, 14'h0404, 14'h0044, 14'h0484, 14'h18EE, 14'h0540};
    int fails = 0, n_checks = 0, i;
    psq_sequencer i_psq_sequencer (.*);
    psq_irq_source i_psq_irq_source (.*);
    always #50 mclk = ~mclk;
    task give_verdict;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        if (i == 40) begin fails++; give_verdict(); end
    endtask
    task rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (i == 40) begin fails++; give_verdict(); end
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        rd(a);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task t_reset;
        rc(OFF_PC_LOW, 32'h0, RESP_OKAY);
        rc(OFF_STATE, 32'h0, RESP_OKAY);
        wr(OFF_TABLE_HIGH, 32'h000000FF);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        rc(OFF_TABLE_HIGH, 32'h0, RESP_OKAY);
        rc(8'h1C, 32'h0, RESP_SLVERR);
        wr(8'h1C, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
    endtask
    task t_table;
        wr(OFF_PM_ADDR, 32'h0);
        foreach (prog[k]) wr(OFF_PM_DATA, {18'h0, prog[k]});
        wr(OFF_PM_ADDR, 32'h706);
        wr(OFF_PM_DATA, 32'h2A5B);
        wr(OFF_CONTROL, 32'h3);
        // About fourteen instruction cycles, dummies included, fit inside this
        repeat (80) @(posedge mclk);
        rc(OFF_TABLE_HIGH, 32'h2A, RESP_OKAY);
        rc(OFF_TABLE_PTR, 32'h06, RESP_OKAY);
        rd(OFF_STATE);
        chk({24'h0, d[15:8]}, 32'hB6);
        chk({28'h0, d[3:0]}, 32'hA);
        chk({29'h0, d[6:4]}, 32'h0);
    endtask
    task t_irq;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        for (i = 0; i < 60 && acks == 4'h0; i++) @(posedge mclk);
        chk({28'h0, acks}, 32'h1);
        rd(OFF_STATE);
        chk({29'h0, d[6:4]}, 32'h1);
        // Bus jump into the subroutine; its return unwinds the interrupt frame
        wr(OFF_PC_LOW, 32'h07);
        repeat (60) @(posedge mclk);
        rd(OFF_STATE);
        chk({29'h0, d[6:4]}, 32'h0);
    endtask
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, fire, s_axi_awaddr} = '0;
        {s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset;
        t_table;
        t_irq;
        give_verdict;
    end
endmodule // testbench
`default_nettype wire
